// ===== verilog/cpd_map.svh
// Offsets, field positions, reset values and counts for the code protection block.
`ifndef CPD_MAP_SVH
`define CPD_MAP_SVH
// ==========================================
// Configuration word
`define CPD_CFG_ADDR 16'hFFF8
`define CPD_CP_BIT 0
`define CPD_DBG_BIT 1
`define CPD_CFG_RESET 16'hFFFF
// ==========================================
// Serial frame: op, address, data
`define CPD_FRAME_LAST 6'h21
`define CPD_OP_HI 33
`define CPD_OP_LO 32
`define CPD_ADDR_HI 31
`define CPD_ADDR_LO 16
`define CPD_DATA_HI 15
`define CPD_OP_READ 2'h1
`define CPD_OP_WRITE 2'h2
`define CPD_OP_CFG 2'h3
`define CPD_SEND_LAST 4'hF
// ==========================================
// Debugger reservations
`define CPD_DBG_STACK 2'h2
`define CPD_DBG_PM_BYTES 10'h200
`define CPD_DBG_DM_BYTES 4'hA
`endif

// ===== verilog/cpd_pkg.sv
// Types shared by the code protection block.
package cpd_pkg;
   typedef struct packed {
      logic        req;
      logic        write;
      logic [15:0] addr;
      logic [15:0] wdata;
   } cpd_mem_req_t;
   typedef struct packed {
      logic       pinsOwned;
      logic [1:0] stackLevels;
      logic [9:0] progBytes;
      logic [3:0] dataBytes;
   } cpd_debug_res_t;
   typedef enum logic [2:0] {
      CPD_LOAD,
      CPD_LOAD_WAIT,
      CPD_RUN,
      CPD_EXEC,
      CPD_SEND
   } cpd_state_t;
endpackage

// ===== verilog/cpd_code_protect.sv
// Configuration load, write-once guard, parity watch, code protection and serial access.
`timescale 1ns/1ps
`include "cpd_map.svh"

// Overview of operation
// - One protect bit guards all program memory.
// - Protect bit refuses external memory reads, writes.
// - Core fetches and accesses never see protection.
// - Each config bit changes once per power.
// - Parity mismatch on config raises device reset.
// - Config loads from flash configuration word.
// - Protect bit also blocks flash config words.
// - Programmer clocks pin A, data on B.
// - Debug enabled only when debug bit zero.
// - Debug reserves pins, stack, memory bytes.
module cpd_code_protect (
   input  wire logic                    clock,
   input  wire logic                    rstn,
   input  wire logic                    monitorLinkPinAIn,
   input  wire logic                    monitorLinkPinBIn,
   output logic                         monitorLinkPinBOut,
   output logic                         monitorLinkPinBOe,
   output cpd_pkg::cpd_mem_req_t        memReq,
   input  wire logic                    memAck,
   input  wire logic [15:0]             memRdata,
   output logic                         coreRstn,
   output logic                         deviceResetReq,
   output logic                         accessRefused,
   output logic                         codeProtect,
   output logic                         debugEnable,
   output cpd_pkg::cpd_debug_res_t      debugRes
);
   import cpd_pkg::*;

   // ==========================================
   // Pin synchronisers
   logic clkS1_reg;
   logic clkS2_reg;
   logic clkS3_reg;
   logic datS1_reg;
   logic datS2_reg;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         clkS1_reg <= 1'b0;
         clkS2_reg <= 1'b0;
         clkS3_reg <= 1'b0;
         datS1_reg <= 1'b0;
         datS2_reg <= 1'b0;
      end else begin
         clkS1_reg <= monitorLinkPinAIn;
         clkS2_reg <= clkS1_reg;
         clkS3_reg <= clkS2_reg;
         datS1_reg <= monitorLinkPinBIn;
         datS2_reg <= datS1_reg;
      end
   end

   // The programmer owns the serial clock, so only its sampled rising edge counts.
   wire clkRise = clkS2_reg & ~clkS3_reg;

   // ==========================================
   // State
   cpd_state_t     state_reg;
   cpd_state_t     state_next;
   logic [15:0]    cfg_reg;
   logic [15:0]    cfg_next;
   logic           refPar_reg;
   logic           refPar_next;
   logic [15:0]    pgmd_reg;
   logic [15:0]    pgmd_next;
   logic [33:0]    shift_reg;
   logic [5:0]     bitCnt_reg;
   logic [15:0]    out_reg;
   logic [3:0]     outCnt_reg;
   logic           oe_reg;
   cpd_mem_req_t   memReq_reg;
   cpd_mem_req_t   memReq_next;
   logic           coreRstn_reg;
   logic           devRst_reg;
   logic           refused_reg;
   logic           dbgEn_reg;
   cpd_debug_res_t dbgRes_reg;

   // ==========================================
   // Decoding
   wire [33:0] frame = {shift_reg[32:0], datS2_reg};
   wire [1:0]  op = frame[`CPD_OP_HI:`CPD_OP_LO];
   wire [15:0] opAddr = frame[`CPD_ADDR_HI:`CPD_ADDR_LO];
   wire [15:0] opData = frame[`CPD_DATA_HI:0];
   wire        frameDone = (state_reg == CPD_RUN) && clkRise && (bitCnt_reg == `CPD_FRAME_LAST);
   wire        cpOn = cfg_reg[`CPD_CP_BIT];
   // Only the serial path is gated; the core's own memory port never passes through here.
   wire        memOp = (op == `CPD_OP_READ) || (op == `CPD_OP_WRITE);
   // The whole space, the configuration word included, falls under the one bit.
   wire        refuse = frameDone && memOp && cpOn;
   wire        grant = frameDone && memOp && !cpOn;
   wire        cfgWr = frameDone && (op == `CPD_OP_CFG);
   // A bit already programmed this power cycle keeps its value.
   wire [15:0] cfgMask = ~pgmd_reg & (opData ^ cfg_reg);
   wire        running = (state_reg != CPD_LOAD) && (state_reg != CPD_LOAD_WAIT);
   wire        parityBad = running && ((^cfg_reg) != refPar_reg);
   wire        sendDone = (state_reg == CPD_SEND) && clkRise && (outCnt_reg == `CPD_SEND_LAST);

   // ==========================================
   // Next-state logic
   always_comb begin
      state_next = state_reg;
      cfg_next = cfg_reg;
      refPar_next = refPar_reg;
      pgmd_next = pgmd_reg;
      memReq_next = memReq_reg;
      case (state_reg)
         CPD_LOAD: begin
            memReq_next = '{req: 1'b1, write: 1'b0, addr: `CPD_CFG_ADDR, wdata: 16'h0000};
            state_next = CPD_LOAD_WAIT;
         end
         CPD_LOAD_WAIT: begin
            if (memAck) begin
               cfg_next = memRdata;
               refPar_next = ^memRdata;
               memReq_next.req = 1'b0;
               state_next = CPD_RUN;
            end
         end
         CPD_RUN: begin
            if (grant) begin
               memReq_next = '{req: 1'b1, write: op == `CPD_OP_WRITE, addr: opAddr, wdata: opData};
               state_next = CPD_EXEC;
            end else if (refuse && op == `CPD_OP_READ) begin
               state_next = CPD_SEND;
            end else if (cfgWr) begin
               cfg_next = (cfg_reg & ~cfgMask) | (opData & cfgMask);
               pgmd_next = pgmd_reg | cfgMask;
               refPar_next = ^((cfg_reg & ~cfgMask) | (opData & cfgMask));
            end
         end
         CPD_EXEC: begin
            if (memAck) begin
               memReq_next.req = 1'b0;
               state_next = memReq_reg.write ? CPD_RUN : CPD_SEND;
            end
         end
         CPD_SEND: begin
            if (sendDone) begin
               state_next = CPD_RUN;
            end
         end
         default: begin
            state_next = CPD_LOAD;
         end
      endcase
      if (parityBad) begin
         state_next = CPD_LOAD;
         memReq_next.req = 1'b0;
      end
   end

   // ==========================================
   // Control registers
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_reg <= CPD_LOAD;
         cfg_reg <= `CPD_CFG_RESET;
         refPar_reg <= 1'b0;
         pgmd_reg <= 16'h0000;
         memReq_reg <= '0;
         coreRstn_reg <= 1'b0;
         devRst_reg <= 1'b0;
         refused_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cfg_reg <= cfg_next;
         refPar_reg <= refPar_next;
         pgmd_reg <= pgmd_next;
         memReq_reg <= memReq_next;
         coreRstn_reg <= (state_next != CPD_LOAD) && (state_next != CPD_LOAD_WAIT);
         devRst_reg <= parityBad;
         refused_reg <= refuse;
      end
   end

   // ==========================================
   // Serial shifter
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         shift_reg <= '0;
         bitCnt_reg <= 6'h00;
      end else if (state_reg != CPD_RUN) begin
         bitCnt_reg <= 6'h00;
      end else if (clkRise) begin
         shift_reg <= frame;
         bitCnt_reg <= frameDone ? 6'h00 : bitCnt_reg + 6'h01;
      end
   end

   // A refused read still clocks out a word, as all zeros, so the frame timing never changes.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         out_reg <= 16'h0000;
         outCnt_reg <= 4'h0;
         oe_reg <= 1'b0;
      end else if (state_reg == CPD_EXEC && memAck) begin
         out_reg <= memRdata;
         outCnt_reg <= 4'h0;
         oe_reg <= !memReq_reg.write;
      end else if (refuse) begin
         out_reg <= 16'h0000;
         outCnt_reg <= 4'h0;
         oe_reg <= op == `CPD_OP_READ;
      end else if (state_reg == CPD_SEND && clkRise) begin
         out_reg <= {out_reg[14:0], 1'b0};
         outCnt_reg <= outCnt_reg + 4'h1;
         oe_reg <= !sendDone;
      end else if (state_reg != CPD_SEND) begin
         oe_reg <= 1'b0;
      end
   end

   // ==========================================
   // Debug resources
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         dbgEn_reg <= 1'b0;
         dbgRes_reg <= '0;
      end else begin
         dbgEn_reg <= running && !cfg_reg[`CPD_DBG_BIT];
         if (running && !cfg_reg[`CPD_DBG_BIT]) begin
            dbgRes_reg <= '{pinsOwned: 1'b1, stackLevels: `CPD_DBG_STACK,
               progBytes: `CPD_DBG_PM_BYTES, dataBytes: `CPD_DBG_DM_BYTES};
         end else begin
            dbgRes_reg <= '0;
         end
      end
   end

   // ==========================================
   // Outputs
   assign monitorLinkPinBOut = out_reg[15];
   assign monitorLinkPinBOe = oe_reg;
   assign memReq = memReq_reg;
   assign coreRstn = coreRstn_reg;
   assign deviceResetReq = devRst_reg;
   assign accessRefused = refused_reg;
   assign codeProtect = cfg_reg[`CPD_CP_BIT];
   assign debugEnable = dbgEn_reg;
   assign debugRes = dbgRes_reg;

   // ==========================================
   // Checks
   ext_blocked_a: assert property (@(posedge clock) disable iff (!rstn)
      $rose(memReq_reg.req) && state_reg == CPD_EXEC |-> !cpOn)
      else $error("External access issued while protected.");

   cfg_word_blocked_a: assert property (@(posedge clock) disable iff (!rstn)
      $rose(memReq_reg.req) && memReq_reg.addr == `CPD_CFG_ADDR && coreRstn_reg |-> !cpOn)
      else $error("Configuration word reached while protected.");

   refuse_flag_a: assert property (@(posedge clock) disable iff (!rstn)
      frameDone && memOp && cpOn |=> accessRefused && !memReq_reg.req)
      else $error("Protected access was not refused.");

   write_once_a: assert property (@(posedge clock) disable iff (!rstn)
      running && $past(running) |-> ((cfg_reg ^ $past(cfg_reg)) & $past(pgmd_reg)) == 16'h0000)
      else $error("Programmed configuration bit changed.");

   parity_reset_a: assert property (@(posedge clock) disable iff (!rstn)
      parityBad |=> deviceResetReq && !coreRstn ##1 !deviceResetReq)
      else $error("Parity failure did not reset the device.");

   load_source_a: assert property (@(posedge clock) disable iff (!rstn)
      $rose(coreRstn_reg) |-> cfg_reg == $past(memRdata) && $past(memAck))
      else $error("Configuration not taken from flash word.");

   release_after_a: assert property (@(posedge clock) disable iff (!rstn)
      $rose(coreRstn_reg) |-> (^cfg_reg) == refPar_reg && $past(state_reg) == CPD_LOAD_WAIT)
      else $error("Core released before configuration load.");

   debug_enable_a: assert property (@(posedge clock) disable iff (!rstn)
      running && !cfg_reg[`CPD_DBG_BIT] [*2] |-> debugEnable)
      else $error("Debug not enabled with debug bit clear.");

   debug_res_a: assert property (@(posedge clock) disable iff (!rstn)
      debugEnable |-> debugRes.pinsOwned && debugRes.stackLevels == 2'h2 && debugRes.progBytes == 10'h200
         && debugRes.dataBytes == 4'hA)
      else $error("Debug reservations wrong.");

   debug_off_a: assert property (@(posedge clock) disable iff (!rstn)
      !debugEnable |-> debugRes == '0)
      else $error("Debug reservations held with debug off.");

   core_free_a: assert property (@(posedge clock) disable iff (!rstn)
      running && $past(running) |-> coreRstn_reg)
      else $error("Protection held the core in reset.");

   refuse_pulse_a: assert property (@(posedge clock) disable iff (!rstn)
      accessRefused |-> !monitorLinkPinBOut ##1 !accessRefused)
      else $error("Refused access leaked data or held the flag.");

   serial_frame_a: assert property (@(posedge clock) disable iff (!rstn)
      frameDone && op == `CPD_OP_CFG |=> bitCnt_reg == 6'h00 && state_reg == CPD_RUN)
      else $error("Serial frame did not close.");
endmodule

// ===== sim/cpd_programmer.sv
// Serial programmer model that drives the two-line programming link.
`timescale 1ns/1ps
module cpd_programmer (
   input  wire logic clock,
   input  wire logic pinBOut,
   input  wire logic pinBOe,
   output logic      pinA,
   output logic      pinBWire
);
   logic hostBit   = 1'b1;
   logic hostDrive = 1'b0;
   logic lastLevel = 1'b1;
   initial pinA = 1'b0;
   // ==========================================
   // Wire level
   // A released line toggles every cycle, so a stale bit can never pass for data.
   assign pinBWire = pinBOe ? pinBOut : (hostDrive ? hostBit : ~lastLevel);
   always @(posedge clock) begin
      lastLevel <= pinBWire;
   end
   // ==========================================
   // Frames
   task automatic sendFrame(input logic [33:0] frame);
      for (int i = 33; i >= 0; i--) begin
         @(posedge clock);
         hostDrive <= 1'b1;
         hostBit <= frame[i];
         pinA <= 1'b0;
         repeat (4) @(posedge clock);
         pinA <= 1'b1;
         repeat (5) @(posedge clock);
      end
      @(posedge clock);
      pinA <= 1'b0;
      hostDrive <= 1'b0;
   endtask
   task automatic readWord(output logic [15:0] word, output logic ok);
      ok = 1'b0;
      word = 16'h0000;
      for (int w = 0; w < 200 && !ok; w++) begin
         @(posedge clock);
         ok = (pinBOe === 1'b1);
      end
      if (ok) begin
         for (int i = 15; i >= 0; i--) begin
            repeat (4) @(posedge clock);
            word[i] = pinBWire;
            pinA <= 1'b1;
            repeat (5) @(posedge clock);
            pinA <= 1'b0;
         end
      end
   endtask
endmodule

// ===== sim/code_protect_debug_config_tb.sv
// Self-checking bench for the code protection and debug configuration block.
`timescale 1ns/1ps
`include "cpd_map.svh"
module code_protect_debug_config_tb;
   import cpd_pkg::*;
   logic           clock = 1'b0;
   logic           rstn  = 1'b0;
   logic           pinA;
   logic           pinBWire;
   logic           pinBOut;
   logic           pinBOe;
   cpd_mem_req_t   memReq;
   logic           memAck   = 1'b0;
   logic [15:0]    memRdata = 16'h0000;
   logic           coreRstn;
   logic           deviceResetReq;
   logic           accessRefused;
   logic           codeProtect;
   logic           debugEnable;
   cpd_debug_res_t debugRes;
   logic [15:0]    flashCfg = 16'hFFFC;
   cpd_mem_req_t   lastReq;
   logic           coreAtAck;
   int             reqCount;
   int             refusedCount;
   int             resetCount;
   int             reqBase;
   int             refusedBase;
   int             errTotal;
   int             checksDone;
   initial begin
      forever #4 clock = ~clock;
   end
   cpd_code_protect i_cpd_code_protect (.clock(clock), .rstn(rstn), .monitorLinkPinAIn(pinA),
      .monitorLinkPinBIn(pinBWire), .monitorLinkPinBOut(pinBOut), .monitorLinkPinBOe(pinBOe),
      .memReq(memReq), .memAck(memAck), .memRdata(memRdata), .coreRstn(coreRstn),
      .deviceResetReq(deviceResetReq), .accessRefused(accessRefused), .codeProtect(codeProtect),
      .debugEnable(debugEnable), .debugRes(debugRes));
   cpd_programmer i_cpd_programmer (.clock(clock), .pinBOut(pinBOut), .pinBOe(pinBOe), .pinA(pinA),
      .pinBWire(pinBWire));
   // ==========================================
   // Program memory model
   always @(posedge clock) begin
      memAck <= memReq.req && !memAck;
      memRdata <= (memReq.addr == 16'hFFF8) ? flashCfg : memReq.addr ^ 16'h5A5A;
      if (memReq.req && !memAck) begin
         lastReq <= memReq;
         reqCount <= reqCount + 1;
      end
      if (memAck) begin
         coreAtAck <= coreRstn;
      end
      if (accessRefused === 1'b1) begin
         refusedCount <= refusedCount + 1;
      end
      if (deviceResetReq === 1'b1) begin
         resetCount <= resetCount + 1;
      end
   end
   // ==========================================
   // Shared tasks
   task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
      checksDone++;
      if (got !== exp) begin
         errTotal++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic completeRun();
      $display("Comparisons %0d, mismatches %0d", checksDone, errTotal);
      if (errTotal == 0 && checksDone > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic clearCounts();
      @(posedge clock);
      reqBase = reqCount;
      refusedBase = refusedCount;
   endtask
   // ==========================================
   // Scenarios
   task automatic bootCheck(input logic expCp);
      logic ok;
      rstn <= 1'b0;
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      ok = 1'b0;
      for (int w = 0; w < 100 && !ok; w++) begin
         @(posedge clock);
         ok = (coreRstn === 1'b1);
      end
      repeat (2) @(posedge clock);
      check("coreRstn", 1, ok);
      if (!ok) begin
         completeRun();
      end
      check("deviceResetReq", 0, deviceResetReq);
      check("coreRstn at load answer", 0, coreAtAck);
      check("load address", 16'hFFF8, lastReq.addr);
      check("load is read", 0, lastReq.write);
      check("codeProtect", expCp, codeProtect);
      check("debugEnable", 1, debugEnable);
      check("debugRes", {1'b1, 2'h2, 10'h200, 4'hA}, debugRes);
   endtask
   task automatic doRead(input logic [15:0] addr, input logic guarded);
      logic [15:0] word;
      logic ok;
      clearCounts();
      i_cpd_programmer.sendFrame({2'h1, addr, 16'h0000});
      i_cpd_programmer.readWord(word, ok);
      check("read answered", 1, ok);
      if (!ok) begin
         errTotal++;
         completeRun();
      end
      check("read data", guarded ? 16'h0000 : ((addr == `CPD_CFG_ADDR) ? flashCfg : addr ^ 16'h5A5A), word);
      check("read refusals", guarded, refusedCount - refusedBase);
      check("read memory requests", !guarded, reqCount - reqBase);
      check("coreRstn during access", 1, coreRstn);
   endtask
   task automatic doWrite(input logic [15:0] addr, input logic [15:0] data, input logic guarded);
      clearCounts();
      i_cpd_programmer.sendFrame({2'h2, addr, data});
      for (int w = 0; w < 50 && reqCount == reqBase && refusedCount == refusedBase; w++) begin
         @(posedge clock);
      end
      repeat (3) @(posedge clock);
      check("write refusals", guarded, refusedCount - refusedBase);
      check("write memory requests", !guarded, reqCount - reqBase);
      if (!guarded) begin
         check("write request", {1'b1, 1'b1, addr, data}, lastReq);
      end
   endtask
   task automatic cfgWrite(input logic [15:0] data, input logic expCp, input logic expDbg);
      i_cpd_programmer.sendFrame({2'h3, 16'h0000, data});
      repeat (4) @(posedge clock);
      check("codeProtect", expCp, codeProtect);
      check("debugEnable", expDbg, debugEnable);
      check("debugRes", expDbg ? {1'b1, 2'h2, 10'h200, 4'hA} : 16'h0000, debugRes);
      check("device resets", 0, resetCount);
      check("coreRstn after config", 1, coreRstn);
   endtask
   // ==========================================
   // Main sequence
   initial begin
      errTotal = 0;
      checksDone = 0;
      bootCheck(1'b0);
      doRead(16'h0123, 1'b0);
      doWrite(16'h0200, 16'hBEEF, 1'b0);
      cfgWrite(16'hFFFF, 1'b1, 1'b0);
      doRead(16'h0123, 1'b1);
      doRead(16'hFFF8, 1'b1);
      doWrite(16'h7FFE, 16'h1234, 1'b1);
      // A second change of an already programmed bit must not land.
      cfgWrite(16'hFFFC, 1'b1, 1'b0);
      bootCheck(1'b0);
      doRead(16'hFFF8, 1'b0);
      completeRun();
   end
endmodule
